// >>> vdib_top.sv
// Top: secondary interrupt flags, mask, polarity and the interrupt pin.
// Assumes the register port and the condition inputs are on MCLK_I;
// the pin's pull-up and wired level are resolved outside.
`timescale 1ns/1ps
`default_nettype none
module vdib_top (
  input  wire logic        MCLK_I,
  input  wire logic        ARST_N_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic        REG_WR_I,
  input  wire logic [7:0]  REG_WDATA_I,
  input  wire logic        REG_RD_I,
  output logic      [7:0]  REG_RDATA_O,
  input  wire logic        INIT_DONE_I,
  input  wire logic        COPY_DETECT_I,
  input  wire logic        FIELD_RATE_I,
  input  wire logic        LINE_ALT_I,
  input  wire logic        COLOR_LOCK_I,
  input  wire logic        SYNC_LOCK_I,
  input  wire logic        LINE_STROBE_I,
  input  wire logic        FRAME_STROBE_I,
  output logic             SOURCE_TYPE_STANDARD_FLAG_O,
  output logic             HOST_INTERRUPT_PIN_O,
  output logic             HOST_INTERRUPT_PIN_OE_O
);

  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] target);
    wr_hit = wr && (addr == target);
  endfunction

  // Reset release through two flops
  logic       rst_meta_reg;
  logic       rst_n_reg;

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] mask_reg;
  logic       polarity_reg;
  logic       int_active_reg;
  logic [7:0] rdata_reg;
  logic [7:0] prev_reg;
  logic       primed_reg;
  logic [9:0] line_cnt_reg;
  logic [9:0] line_cnt_next;
  logic       frame_seen_reg;
  logic       src_std_reg;
  logic       src_std_next;

  wire        wr_clear_w  = wr_hit(REG_WR_I, REG_ADDR_I, vdib_pkg::ADDR_CLEAR);
  wire        wr_mask_w   = wr_hit(REG_WR_I, REG_ADDR_I, vdib_pkg::ADDR_MASK);
  wire        wr_config_w = wr_hit(REG_WR_I, REG_ADDR_I,
                                   vdib_pkg::ADDR_CONFIG);

  // Bits to clear this cycle; reserved bit ignored
  wire  [7:0] clr_bits_w  = wr_clear_w ?
                            (REG_WDATA_I & vdib_pkg::FLAG_BITS) :
                            vdib_pkg::RST_BYTE;
  wire  [7:0] mask_wr_w   = REG_WDATA_I & vdib_pkg::FLAG_BITS;

  // Monitored levels in status bit order
  wire  [7:0] mon_w = {INIT_DONE_I, COPY_DETECT_I, 1'b0, FIELD_RATE_I,
                       LINE_ALT_I, COLOR_LOCK_I, SYNC_LOCK_I, src_std_reg};

  // Change events; none until the previous levels are captured
  wire  [7:0] ev_w = primed_reg ?
                     (((mon_w ^ prev_reg) & vdib_pkg::CHANGE_BITS) |
                      (mon_w & ~prev_reg & vdib_pkg::RISE_BITS)) :
                     vdib_pkg::RST_BYTE;

  // Event wins over a clear in the same cycle
  assign status_next = (status_reg & ~clr_bits_w) | ev_w;

  wire  [7:0] pend_w  = status_reg & mask_reg;
  wire        pend_any_w = |pend_w;

  // Lines per frame classification
  wire        frame_end_w = FRAME_STROBE_I && frame_seen_reg;
  wire        std_count_w = (line_cnt_reg == vdib_pkg::LINES_525) ||
                            (line_cnt_reg == vdib_pkg::LINES_625);
  assign src_std_next = frame_end_w ? std_count_w : src_std_reg;

  assign line_cnt_next =
    FRAME_STROBE_I ? (LINE_STROBE_I ? vdib_pkg::LINES_ONE :
                                      vdib_pkg::LINES_ZERO) :
    (LINE_STROBE_I && line_cnt_reg != vdib_pkg::LINES_MAX) ?
      line_cnt_reg + vdib_pkg::LINES_ONE : line_cnt_reg;

  // Read mux; clear register reads as zero
  wire  [7:0] rd_mux_w =
    (REG_ADDR_I == vdib_pkg::ADDR_MASK)   ? mask_reg :
    (REG_ADDR_I == vdib_pkg::ADDR_CONFIG) ?
      {7'h00, polarity_reg} :
    (REG_ADDR_I == vdib_pkg::ADDR_STATUS) ? status_reg :
    (REG_ADDR_I == vdib_pkg::ADDR_ACTIVE) ?
      {7'h00, int_active_reg} :
    vdib_pkg::RST_BYTE;

  always_ff @(posedge MCLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      status_reg <= vdib_pkg::RST_BYTE;
      prev_reg   <= vdib_pkg::RST_BYTE;
      primed_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      prev_reg   <= mon_w;
      primed_reg <= 1'b1;
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mask_reg     <= vdib_pkg::RST_BYTE;
      polarity_reg <= 1'b0;
    end else begin
      if (wr_mask_w) begin
        mask_reg <= mask_wr_w;
      end
      if (wr_config_w) begin
        polarity_reg <= REG_WDATA_I[vdib_pkg::BIT_POLARITY];
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      int_active_reg <= 1'b0;
      rdata_reg      <= vdib_pkg::RST_BYTE;
    end else begin
      int_active_reg <= pend_any_w;
      if (REG_RD_I) begin
        rdata_reg <= rd_mux_w;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      line_cnt_reg   <= vdib_pkg::LINES_ZERO;
      frame_seen_reg <= 1'b0;
      src_std_reg    <= vdib_pkg::RST_SRC_STD;
    end else begin
      line_cnt_reg   <= line_cnt_next;
      frame_seen_reg <= frame_seen_reg | FRAME_STROBE_I;
      src_std_reg    <= src_std_next;
    end
  end

  assign REG_RDATA_O                 = rdata_reg;
  assign SOURCE_TYPE_STANDARD_FLAG_O = src_std_reg;
  // Open drain when active low, push-pull when active high
  assign HOST_INTERRUPT_PIN_O    =
    polarity_reg & int_active_reg;
  assign HOST_INTERRUPT_PIN_OE_O =
    polarity_reg | int_active_reg;

  // Polarity match with the primary interrupt is left to the host

  // Checks
  property p_clear_bits;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    (wr_clear_w && ev_w == vdib_pkg::RST_BYTE) |=>
      (status_reg & $past(clr_bits_w)) == vdib_pkg::RST_BYTE;
  endproperty
  a_clear_bits: assert property (p_clear_bits)
    else $error("cleared flag still set");

  property p_zero_keeps;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    wr_clear_w |=> ((status_reg ^ $past(status_reg)) &
                    ~$past(clr_bits_w) & ~$past(ev_w)) == vdib_pkg::RST_BYTE;
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("flag changed without clear or event");

  property p_nonstandard;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    (frame_end_w && !std_count_w) |=> !SOURCE_TYPE_STANDARD_FLAG_O;
  endproperty
  a_nonstandard: assert property (p_nonstandard)
    else $error("nonstandard count not flagged");

  property p_mask_blocks;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    (pend_w == vdib_pkg::RST_BYTE) [*2] |-> !int_active_reg;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("interrupt active with nothing pending");

  property p_event_sets;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    (ev_w != vdib_pkg::RST_BYTE) |=> (status_reg & $past(ev_w)) == $past(ev_w);
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("event lost");

  property p_active_read;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    (REG_RD_I && REG_ADDR_I == vdib_pkg::ADDR_ACTIVE) |=>
      REG_RDATA_O[vdib_pkg::BIT_ACTIVE] == $past(int_active_reg);
  endproperty
  a_active_read: assert property (p_active_read)
    else $error("active state misread");

  property p_mask_reserved;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    wr_mask_w |=> mask_reg == ($past(REG_WDATA_I) & vdib_pkg::FLAG_BITS);
  endproperty
  a_mask_reserved: assert property (p_mask_reserved)
    else $error("mask write wrong");

  property p_pin_low;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    !polarity_reg |-> !HOST_INTERRUPT_PIN_O &&
                      (HOST_INTERRUPT_PIN_OE_O == int_active_reg);
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("open drain pin wrong");

  property p_pin_high;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    polarity_reg |-> HOST_INTERRUPT_PIN_OE_O &&
                     (HOST_INTERRUPT_PIN_O == int_active_reg);
  endproperty
  a_pin_high: assert property (p_pin_high)
    else $error("push pull pin wrong");

  property p_set_beats_clear;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    (wr_clear_w && (clr_bits_w & ev_w) != vdib_pkg::RST_BYTE) |=>
      (status_reg & $past(ev_w)) == $past(ev_w);
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("clear beat event");

  property p_active_def;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    1'b1 |=> int_active_reg == |($past(status_reg) & $past(mask_reg));
  endproperty
  a_active_def: assert property (p_active_def)
    else $error("active state not flag and mask");

  property p_reserved_zero;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    ((status_reg | mask_reg) & ~vdib_pkg::FLAG_BITS) == vdib_pkg::RST_BYTE;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit set");

  property p_src_hold;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    !frame_end_w |=> $stable(SOURCE_TYPE_STANDARD_FLAG_O);
  endproperty
  a_src_hold: assert property (p_src_hold)
    else $error("source type changed outside frame end");

  property p_standard;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    (frame_end_w && std_count_w) |=> SOURCE_TYPE_STANDARD_FLAG_O;
  endproperty
  a_standard: assert property (p_standard)
    else $error("standard count not flagged");

  property p_init_rise;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    (primed_reg && INIT_DONE_I && !prev_reg[vdib_pkg::BIT_INIT]) |=>
      status_reg[vdib_pkg::BIT_INIT];
  endproperty
  a_init_rise: assert property (p_init_rise)
    else $error("init ready flag not set");

  property p_change_sets;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    primed_reg |=> (~status_reg & ($past(mon_w) ^ $past(prev_reg)) &
                    vdib_pkg::CHANGE_BITS) == vdib_pkg::RST_BYTE;
  endproperty
  a_change_sets: assert property (p_change_sets)
    else $error("change did not set its flag");

  property p_clear_reads_zero;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    (REG_RD_I && REG_ADDR_I == vdib_pkg::ADDR_CLEAR) |=>
      REG_RDATA_O == vdib_pkg::RST_BYTE;
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero)
    else $error("clear register read not zero");

  property p_config_read;
    @(posedge MCLK_I) disable iff (!rst_n_reg)
    (REG_RD_I && REG_ADDR_I == vdib_pkg::ADDR_CONFIG) |=>
      REG_RDATA_O == {7'h00, $past(polarity_reg)};
  endproperty
  a_config_read: assert property (p_config_read)
    else $error("config read wrong");

  c_irq: cover property (@(posedge MCLK_I) disable iff (!rst_n_reg)
    !int_active_reg ##1 int_active_reg);
  c_race: cover property (@(posedge MCLK_I) disable iff (!rst_n_reg)
    wr_clear_w && (clr_bits_w & ev_w) != vdib_pkg::RST_BYTE);
  c_nonstd: cover property (@(posedge MCLK_I) disable iff (!rst_n_reg)
    frame_end_w && !std_count_w);
  c_high: cover property (@(posedge MCLK_I) disable iff (!rst_n_reg)
    polarity_reg && int_active_reg);
  c_std: cover property (@(posedge MCLK_I) disable iff (!rst_n_reg)
    frame_end_w && std_count_w);

endmodule
`default_nettype wire

// >>> vdib_pkg.sv
// Package: register map, field layout, reset values and line counts
// for the secondary interrupt logic of the video decoder.
// Assumes a decoded byte register port from the serial host engine.
//
// What this block does
// - A one written to a clear bit zeroes its flag; zeros do nothing.
// - Clear resets to zero; bits 7,6,4-0 clear flags; bit 5 reserved.
// - Source is nonstandard when lines per frame are not standard.
// - A mask one lets a set flag drive the pin; a zero blocks it.
// - Flags set regardless of mask; the mask only gates the pin.
// - Active one cycle after a flag and its mask bit are both one; readable.
// - Mask shares clear bit positions, bit 5 reserved, resets to zero.
// - Config bit 0 picks polarity: 0 active low at reset, 1 active high.
// - Active low: pull pin low when active, release when inactive.
// - Active high: drive pin high when active, low when inactive.
// - Status changes of the monitored conditions set their flags; init only on a rise.
// - Completed internal initialization sets the init-ready flag.
package vdib_pkg;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 8;
  localparam int          LINE_W        = 10;
  // Register offsets
  localparam logic [7:0]  ADDR_CLEAR    = 8'h1C;
  localparam logic [7:0]  ADDR_MASK     = 8'h1D;
  localparam logic [7:0]  ADDR_CONFIG   = 8'h1E;
  localparam logic [7:0]  ADDR_STATUS   = 8'h86;
  localparam logic [7:0]  ADDR_ACTIVE   = 8'hC3;
  // Field positions
  localparam int          BIT_INIT      = 7;
  localparam int          BIT_COPY      = 6;
  localparam int          BIT_FIELD     = 4;
  localparam int          BIT_LALT      = 3;
  localparam int          BIT_COLOR     = 2;
  localparam int          BIT_SYNC      = 1;
  localparam int          BIT_SOURCE    = 0;
  localparam int          BIT_POLARITY  = 0;
  localparam int          BIT_ACTIVE    = 0;
  // Bits that exist in clear, mask and status
  localparam logic [7:0]  FLAG_BITS     = 8'hDF;
  // Bits raised on any change of level
  localparam logic [7:0]  CHANGE_BITS   = 8'h5F;
  // Bit raised on a rising level only
  localparam logic [7:0]  RISE_BITS     = 8'h80;
  // Reset values
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic        RST_SRC_STD   = 1'b1;
  // Standard lines per frame
  localparam logic [9:0]  LINES_525     = 10'h20D;
  localparam logic [9:0]  LINES_625     = 10'h271;
  localparam logic [9:0]  LINES_MAX     = 10'h3FF;
  localparam logic [9:0]  LINES_ONE     = 10'h001;
  localparam logic [9:0]  LINES_ZERO    = 10'h000;
endpackage

// >>> vdib_host.sv
// Host model: byte register strobes and the interrupt wire.
// Assumes it shares the decoder clock; the wire has a pull-up.
`timescale 1ns/1ps
`default_nettype none
module vdib_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       pin_i,
  input  wire logic       pin_oe_i,
  output logic      [7:0] addr_o,
  output logic            wr_o,
  output logic      [7:0] wdata_o,
  output logic            rd_o,
  output logic            level_o
);
  // Released wire floats to the pull-up
  assign level_o = pin_oe_i ? pin_i : 1'b1;
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    #1;
    d = rdata_i;
  endtask
  // Polarity kept equal to the primary interrupt's
  task automatic pol(input logic p);
    wr(vdib_pkg::ADDR_CONFIG, {7'h00, p});
  endtask
endmodule
`default_nettype wire

// >>> video_decoder_interrupt_b_test.sv
// Testbench: flag table, source classing, polarity and clear races.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
`default_nettype none
module video_decoder_interrupt_b_test;
  logic       clk;
  logic       arst_n;
  logic [5:0] cond;
  logic       line_stb;
  logic       frame_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] q;
  logic       wr;
  logic       rd;
  logic       src;
  logic       pin;
  logic       oe;
  logic       lvl;
  int         fail_count;
  int         samples_checked;
  localparam logic [5:0] ROW_COND [6] = '{6'h20, 6'h10, 6'h08,
                                         6'h04, 6'h02, 6'h01};
  localparam logic [7:0] ROW_FLAG [6] = '{8'h80, 8'h40, 8'h10,
                                         8'h08, 8'h04, 8'h02};
  vdib_top dut (.MCLK_I(clk), .ARST_N_I(arst_n), .REG_ADDR_I(addr),
    .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RD_I(rd),
    .REG_RDATA_O(rdata), .INIT_DONE_I(cond[5]), .COPY_DETECT_I(cond[4]),
    .FIELD_RATE_I(cond[3]), .LINE_ALT_I(cond[2]), .COLOR_LOCK_I(cond[1]),
    .SYNC_LOCK_I(cond[0]), .LINE_STROBE_I(line_stb),
    .FRAME_STROBE_I(frame_stb), .SOURCE_TYPE_STANDARD_FLAG_O(src),
    .HOST_INTERRUPT_PIN_O(pin), .HOST_INTERRUPT_PIN_OE_O(oe));
  vdib_host host (.clk_i(clk), .rdata_i(rdata), .pin_i(pin),
    .pin_oe_i(oe), .addr_o(addr), .wr_o(wr), .wdata_o(wdata),
    .rd_o(rd), .level_o(lvl));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, q);
    chk(q, exp);
  endtask
  // Lines then a closing frame strobe
  task automatic frame(input int n);
    repeat (n) begin
      @(posedge clk) line_stb <= 1'b1;
      @(posedge clk) line_stb <= 1'b0;
    end
    @(posedge clk) frame_stb <= 1'b1;
    @(posedge clk) frame_stb <= 1'b0;
    idle(3);
  endtask
  task automatic results();
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end
  initial begin
    arst_n = 1'b0;
    cond = 6'h00;
    line_stb = 1'b0;
    frame_stb = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    idle(3);
    chk({6'h00, oe, src}, 8'h01);
    rchk(vdib_pkg::ADDR_CLEAR, 8'h00);
    rchk(vdib_pkg::ADDR_MASK, 8'h00);
    rchk(vdib_pkg::ADDR_CONFIG, 8'h00);
    rchk(vdib_pkg::ADDR_STATUS, 8'h00);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) cond <= cond ^ ROW_COND[i];
      idle(3);
      rchk(vdib_pkg::ADDR_STATUS, ROW_FLAG[i]);
      chk({6'h00, oe, lvl}, 8'h01);
      host.wr(vdib_pkg::ADDR_MASK, 8'hFF);
      rchk(vdib_pkg::ADDR_MASK, 8'hDF);
      rchk(vdib_pkg::ADDR_ACTIVE, 8'h01);
      chk({6'h00, oe, lvl}, 8'h02);
      host.wr(vdib_pkg::ADDR_CLEAR, ~ROW_FLAG[i]);
      rchk(vdib_pkg::ADDR_STATUS, ROW_FLAG[i]);
      host.wr(vdib_pkg::ADDR_CLEAR, ROW_FLAG[i]);
      rchk(vdib_pkg::ADDR_STATUS, 8'h00);
      chk({6'h00, oe, lvl}, 8'h01);
      host.wr(vdib_pkg::ADDR_MASK, 8'h00);
    end
    rchk(8'h40, 8'h00);
    frame(0);
    frame(624);
    chk({7'h00, src}, 8'h00);
    rchk(vdib_pkg::ADDR_STATUS, 8'h01);
    host.wr(vdib_pkg::ADDR_CLEAR, 8'h01);
    frame(625);
    chk({7'h00, src}, 8'h01);
    rchk(vdib_pkg::ADDR_STATUS, 8'h01);
    host.wr(vdib_pkg::ADDR_CLEAR, 8'hFF);
    host.pol(1'b1);
    rchk(vdib_pkg::ADDR_CONFIG, 8'h01);
    idle(2);
    chk({6'h00, oe, pin}, 8'h02);
    host.wr(vdib_pkg::ADDR_MASK, 8'h02);
    @(posedge clk) cond <= cond ^ 6'h01;
    idle(3);
    chk({6'h00, oe, pin}, 8'h03);
    host.wr(vdib_pkg::ADDR_CLEAR, 8'h02);
    fork
      host.wr(vdib_pkg::ADDR_CLEAR, 8'h02);
      @(posedge clk) cond <= cond ^ 6'h01;
    join
    idle(2);
    rchk(vdib_pkg::ADDR_STATUS, 8'h02);
    chk({6'h00, oe, pin}, 8'h03);
    host.pol(1'b0);
    idle(2);
    chk({6'h00, oe, lvl}, 8'h02);
    // Reset in mid-run with a flag pending and masked in
    @(posedge clk) arst_n <= 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    idle(3);
    chk({6'h00, oe, src}, 8'h01);
    rchk(vdib_pkg::ADDR_MASK, 8'h00);
    rchk(vdib_pkg::ADDR_CONFIG, 8'h00);
    rchk(vdib_pkg::ADDR_STATUS, 8'h00);
    rchk(vdib_pkg::ADDR_ACTIVE, 8'h00);
    results();
  end
endmodule
`default_nettype wire
